// >>> common/dac_cfg_defs.svh
// constants for the dac configuration and lock control block
// assumes inclusion by bare name from the package file; the design file has no include of its own
`ifndef DAC_CFG_DEFS_SVH
`define DAC_CFG_DEFS_SVH
`define DAC_LOCK_STATUS_ADDR 5'h0b
`define DAC_VOL_CODE0_ADDR 5'h00
`define DAC_VOL_CODE1_ADDR 5'h01
`define DAC_VOL_REF_ADDR 5'h08
`define DAC_VOL_PD_ADDR 5'h09
`define DAC_VOL_GAIN_ADDR 5'h0a
`define DAC_RES_BITS 12
`define DAC_NUM_CH 2
`define DAC_LOCK_W 2
`define DAC_GAIN_LSB 8
`define DAC_LOCK_RESET 2'h0
`define DAC_REG_W 16
`endif

// >>> common/dac_cfg_pkg.sv
// types for the dac configuration and lock control block
// assumes dac_cfg_defs.svh is on the include path
`include "dac_cfg_defs.svh"
package dac_cfg_pkg;
  typedef enum logic [1:0] {
    ref_supply = 2'h0,
    ref_bandgap = 2'h1,
    ref_pin_unbuf = 2'h2,
    ref_pin_buf = 2'h3
  } ref_sel_t;
  typedef enum logic [1:0] {
    pd_normal = 2'h0,
    pd_load_1k = 2'h1,
    pd_load_100k = 2'h2,
    pd_open = 2'h3
  } pd_sel_t;
  typedef enum logic [1:0] {
    st_hold = 2'h0,
    st_pending = 2'h1,
    st_reload = 2'h3
  } upd_state_t;
endpackage : dac_cfg_pkg

// >>> src/dac_config_lock_control.sv
// digital control of a dual-channel resistor-ladder dac: lock status,
// reference select, gain, power-down and volatile dac code.
// assumes: reset is power-on/brown-out, bus writes arrive decoded from the
// serial slave, nonvolatile copies are presented as stable inputs.
module dac_config_lock_control
  import dac_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_stb,
  input wire logic [4:0] wr_addr,
  input wire logic [`DAC_REG_W-1:0] wr_data,
  input wire logic ack_fall,
  input wire logic rd_stb,
  input wire logic [4:0] rd_addr,
  input wire logic gen_call_reset,
  input wire logic [`DAC_NUM_CH-1:0] value_lock_cfg,
  input wire logic [`DAC_NUM_CH-1:0] config_lock_cfg,
  input wire logic [2*`DAC_NUM_CH-1:0] nv_ref_select_field,
  input wire logic [2*`DAC_NUM_CH-1:0] nv_power_down_select,
  input wire logic [`DAC_NUM_CH-1:0] nv_gain,
  input wire logic [2*`DAC_RES_BITS-1:0] nv_code,
  output logic [`DAC_REG_W-1:0] rd_data,
  output logic rd_valid,
  output logic [2*`DAC_RES_BITS-1:0] ladder_tap,
  output logic [`DAC_NUM_CH-1:0] ladder_ref_connect,
  output logic [`DAC_NUM_CH-1:0] ref_pin_connect,
  output logic [`DAC_NUM_CH-1:0] ref_buffer_on,
  output logic [`DAC_NUM_CH-1:0] bandgap_on,
  output logic [`DAC_NUM_CH-1:0] gain_x2,
  output logic [`DAC_NUM_CH-1:0] amp_on,
  output logic [`DAC_NUM_CH-1:0] out_load_1k,
  output logic [`DAC_NUM_CH-1:0] out_load_100k
);
  localparam int RB = `DAC_RES_BITS;
  localparam int NC = `DAC_NUM_CH;

  typedef struct packed {
    upd_state_t st;
    logic boot;
    logic [2*RB-1:0] code;
    logic [2*RB-1:0] code_pend;
    logic [2*NC-1:0] ref_sel;
    logic [2*NC-1:0] ref_pend;
    logic [2*NC-1:0] pd_sel;
    logic [2*NC-1:0] pd_pend;
    logic [NC-1:0] gain;
    logic [NC-1:0] gain_pend;
    logic [2*NC-1:0] lock_status_bits;
    logic [`DAC_REG_W-1:0] rd_data;
    logic rd_valid;
    logic [2*RB-1:0] ladder_tap;
    logic [NC-1:0] ladder_ref_connect;
    logic [NC-1:0] ref_pin_connect;
    logic [NC-1:0] ref_buffer_on;
    logic [NC-1:0] bandgap_on;
    logic [NC-1:0] gain_x2;
    logic [NC-1:0] amp_on;
    logic [NC-1:0] out_load_1k;
    logic [NC-1:0] out_load_100k;
  } state_t;

  // s_r holds every register of the block; s_nxt is its next value
  state_t s_r;
  state_t s_nxt;

  // combinational decode shared by the next-state logic
  logic [NC-1:0] pd_any;
  logic [NC-1:0] ref_sup;
  logic [NC-1:0] g2;
  logic [NC-1:0] pin_sel;
  logic [NC-1:0] bg_sel;
  logic [NC-1:0] bufd;
  logic [NC-1:0] l1k;
  logic [NC-1:0] l100k;

  logic [2*NC-1:0] lock_mirror;
  logic wr_taken;
  logic [`DAC_REG_W-1:0] rd_word;

  // per-channel decode of the nonvolatile lock bits and volatile settings
  for (genvar c = 0; c < NC; c++) begin : g_ch
    ref_sel_t rs;
    pd_sel_t ps;
    logic [1:0] lock_c;
    logic sup_c;
    logic bg_c;
    logic pin_c;
    logic buf_c;
    logic down_c;
    logic l1k_c;
    logic l100k_c;
    assign rs = ref_sel_t'(s_r.ref_sel[2*c +: 2]);
    assign ps = pd_sel_t'(s_r.pd_sel[2*c +: 2]);

    // value lock lands in the high bit, config lock in the low bit
    always_comb begin
      case ({value_lock_cfg[c], config_lock_cfg[c]})
        2'b11: begin
          lock_c = 2'h3;
        end
        2'b10: begin
          lock_c = 2'h2;
        end
        2'b01: begin
          lock_c = 2'h1;
        end
        2'b00: begin
          lock_c = 2'h0;
        end
        default: begin
          lock_c = `DAC_LOCK_RESET;
        end
      endcase
    end
    assign lock_mirror[2*c +: 2] = lock_c;

    // reference source decode, one arm per encoding
    always_comb begin
      sup_c = 1'b0;
      bg_c = 1'b0;
      pin_c = 1'b0;
      buf_c = 1'b0;
      case (rs)
        ref_supply: begin
          sup_c = 1'b1;
        end
        ref_bandgap: begin
          bg_c = 1'b1;
          buf_c = 1'b1;
        end
        ref_pin_unbuf: begin
          pin_c = 1'b1;
        end
        ref_pin_buf: begin
          pin_c = 1'b1;
          buf_c = 1'b1;
        end
        default: begin
          sup_c = 1'b1;
        end
      endcase
    end

    // power-down decode; every state but normal stops the channel
    always_comb begin
      down_c = 1'b1;
      l1k_c = 1'b0;
      l100k_c = 1'b0;
      case (ps)
        pd_normal: begin
          down_c = 1'b0;
        end
        pd_load_1k: begin
          l1k_c = 1'b1;
        end
        pd_load_100k: begin
          l100k_c = 1'b1;
        end
        pd_open: begin
          down_c = 1'b1;
        end
        default: begin
          down_c = 1'b1;
        end
      endcase
    end

    assign pd_any[c] = down_c;
    assign l1k[c] = l1k_c;
    assign l100k[c] = l100k_c;
    assign ref_sup[c] = sup_c;
    assign bg_sel[c] = bg_c;
    assign pin_sel[c] = pin_c;
    assign bufd[c] = buf_c;
    assign g2[c] = s_r.gain[c] && !sup_c;
  end

  // read word assembled from current state; a read only loads rd_data and rd_valid
  always_comb begin
    rd_word = '0;
    case (rd_addr)
      `DAC_LOCK_STATUS_ADDR: begin
        rd_word[2*NC-1:0] = s_r.lock_status_bits;
      end
      `DAC_VOL_CODE0_ADDR: begin
        rd_word[RB-1:0] = s_r.code[RB-1:0];
      end
      `DAC_VOL_CODE1_ADDR: begin
        rd_word[RB-1:0] = s_r.code[2*RB-1:RB];
      end
      `DAC_VOL_REF_ADDR: begin
        rd_word[2*NC-1:0] = s_r.ref_sel;
      end
      `DAC_VOL_PD_ADDR: begin
        rd_word[2*NC-1:0] = s_r.pd_sel;
      end
      `DAC_VOL_GAIN_ADDR: begin
        rd_word[`DAC_GAIN_LSB +: NC] = s_r.gain;
      end
      default: begin
        // unmapped addresses read zero
        rd_word = '0;
      end
    endcase
  end

  // a write to the lock status or an unmapped address leaves nothing pending
  assign wr_taken = wr_stb && (
    wr_addr == `DAC_VOL_CODE0_ADDR ||
    wr_addr == `DAC_VOL_CODE1_ADDR ||
    wr_addr == `DAC_VOL_REF_ADDR ||
    wr_addr == `DAC_VOL_PD_ADDR ||
    wr_addr == `DAC_VOL_GAIN_ADDR);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.boot = 1'b0;
    s_nxt.lock_status_bits = lock_mirror;
    if (s_r.boot || gen_call_reset) begin
      // power-on load and general call both restore the nonvolatile data
      s_nxt.code = nv_code;
      s_nxt.ref_sel = nv_ref_select_field;
      s_nxt.pd_sel = nv_power_down_select;
      s_nxt.gain = nv_gain;
      s_nxt.st = st_hold;
    end else begin
      // writes collect in the pending copies until the acknowledge
      case (s_r.st)
        st_hold, st_pending: begin
          if (wr_stb) begin
            case (wr_addr)
              `DAC_VOL_CODE0_ADDR: begin
                s_nxt.code_pend[RB-1:0] = wr_data[RB-1:0];
              end
              `DAC_VOL_CODE1_ADDR: begin
                s_nxt.code_pend[2*RB-1:RB] = wr_data[RB-1:0];
              end
              `DAC_VOL_REF_ADDR: begin
                s_nxt.ref_pend = wr_data[2*NC-1:0];
              end
              `DAC_VOL_PD_ADDR: begin
                s_nxt.pd_pend = wr_data[2*NC-1:0];
              end
              `DAC_VOL_GAIN_ADDR: begin
                s_nxt.gain_pend = wr_data[`DAC_GAIN_LSB +: NC];
              end
              default: begin
                s_nxt.st = s_r.st;
              end
            endcase
          end
          if (wr_taken) begin
            s_nxt.st = st_pending;
          end
          // an acknowledge in the same cycle as the last write applies it too
          if (ack_fall && (s_r.st == st_pending || wr_taken)) begin
            s_nxt.st = st_reload;
          end
        end
        st_reload: begin
          // writes arriving in the reload cycle are dropped
          s_nxt.code = s_r.code_pend;
          s_nxt.ref_sel = s_r.ref_pend;
          s_nxt.pd_sel = s_r.pd_pend;
          s_nxt.gain = s_r.gain_pend;
          s_nxt.st = st_hold;
        end
        default: begin
          s_nxt.st = st_hold;
        end
      endcase
    end
    if (rd_stb) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_data = rd_word;
    end

    // tap code is unsigned, full scale 2^n-1 one element below the top
    s_nxt.ladder_tap = s_r.code;
    s_nxt.ladder_ref_connect = ~pd_any;
    s_nxt.ref_pin_connect = pin_sel & ~pd_any;
    s_nxt.ref_buffer_on = bufd;
    s_nxt.bandgap_on = bg_sel;
    s_nxt.gain_x2 = g2;
    s_nxt.amp_on = ~pd_any;
    s_nxt.out_load_1k = l1k;
    s_nxt.out_load_100k = l100k;
  end

  // reset clears all state and arms the boot load for the next edge
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.boot <= 1'b1;
      s_r.lock_status_bits <= {NC{`DAC_LOCK_RESET}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output is a flip-flop of the state struct
  assign rd_data = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;
  assign ladder_tap = s_r.ladder_tap;
  assign ladder_ref_connect = s_r.ladder_ref_connect;
  assign ref_pin_connect = s_r.ref_pin_connect;
  assign ref_buffer_on = s_r.ref_buffer_on;
  assign bandgap_on = s_r.bandgap_on;
  assign gain_x2 = s_r.gain_x2;
  assign amp_on = s_r.amp_on;
  assign out_load_1k = s_r.out_load_1k;
  assign out_load_100k = s_r.out_load_100k;
endmodule : dac_config_lock_control

// >>> sim/dac_config_lock_control_checker.sv
// assertions and covers on the control block ports
// assumes a bind by name to the top module, one clock, synchronous reset
module dac_config_lock_control_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_stb,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic ack_fall,
  input wire logic rd_stb,
  input wire logic [4:0] rd_addr,
  input wire logic gen_call_reset,
  input wire logic [1:0] value_lock_cfg,
  input wire logic [1:0] config_lock_cfg,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic [23:0] ladder_tap,
  input wire logic [1:0] ladder_ref_connect,
  input wire logic [1:0] ref_buffer_on,
  input wire logic [1:0] bandgap_on,
  input wire logic [1:0] amp_on,
  input wire logic [1:0] out_load_1k,
  input wire logic [1:0] out_load_100k
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_LOCK: assert property (rd_stb && rd_addr == 5'h0b |=> rd_data[3:0] ==
    {$past(value_lock_cfg[1]), $past(config_lock_cfg[1]), $past(value_lock_cfg[0]),
    $past(config_lock_cfg[0])}) else $error("lock status wrong");
  AST_HIGH: assert property (
    rd_valid && $past(rd_addr) == 5'h0b |-> rd_data[15:4] == 12'h0) else $error("high bits set");
  AST_LADDER: assert property (ladder_ref_connect == amp_on)
    else $error("ladder connected in power-down");
  AST_OPEN: assert property (((out_load_1k | out_load_100k) & amp_on) == 2'h0)
    else $error("amplifier on while loaded");
  AST_BG: assert property ((bandgap_on & ~ref_buffer_on) == 2'h0)
    else $error("band gap without buffer");
  AST_LOADS: assert property ((out_load_1k & out_load_100k) == 2'h0)
    else $error("both loads on");
  AST_APPLY: assert property (wr_stb && wr_addr == 5'h00 && ack_fall && !gen_call_reset
    ##1 (!ack_fall && !gen_call_reset) [*3] |-> ladder_tap[11:0] == $past(wr_data[11:0], 3))
    else $error("code not applied");
  AST_HOLD: assert property ((!ack_fall && !gen_call_reset) [*4] |=> $stable(ladder_tap))
    else $error("tap moved without update");
  cover property (wr_stb && ack_fall);
  cover property (gen_call_reset);
  cover property (rd_valid && rd_data[1:0] == 2'h3);
endmodule : dac_config_lock_control_checker

// >>> sim/dac_host_model.sv
// host side: decoded bus writes, reads and general call reset
// assumes each task is called from the bench's main sequence
module dac_host_model (
  input wire logic clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  output logic wr_stb = 1'b0,
  output logic [4:0] wr_addr = '0,
  output logic [15:0] wr_data = '0,
  output logic ack_fall = 1'b0,
  output logic rd_stb = 1'b0,
  output logic [4:0] rd_addr = '0,
  output logic gen_call_reset = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic ack);
    @(posedge clk);
    {wr_stb, wr_addr, wr_data, ack_fall} <= {1'b1, a, d, ack};
    @(posedge clk);
    {wr_stb, wr_data, ack_fall} <= {1'b0, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [16:0] q);
    @(posedge clk);
    {rd_stb, rd_addr} <= {1'b1, a};
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 q = {rd_valid, rd_data};
  endtask : rd
  task automatic gc();
    @(posedge clk);
    gen_call_reset <= 1'b1;
    @(posedge clk);
    gen_call_reset <= 1'b0;
  endtask : gc
endmodule : dac_host_model

// >>> sim/tb_dac_config_lock_control.sv
// top bench: setting table, then lock status, write hold and reload cases
// assumes the design, host model and checker are compiled first
module tb_dac_config_lock_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr_stb, ack_fall, rd_stb, gen_call_reset, rd_valid;
  logic [4:0] wr_addr, rd_addr;
  logic [15:0] wr_data, rd_data;
  logic [1:0] value_lock_cfg = '0, config_lock_cfg = '0, nv_gain = '0;
  logic [1:0] ladder_ref_connect, ref_pin_connect, ref_buffer_on, bandgap_on, gain_x2;
  logic [1:0] amp_on, out_load_1k, out_load_100k;
  logic [3:0] nv_ref_select_field = '0, nv_power_down_select = '0;
  logic [23:0] nv_code = '0, ladder_tap;
  logic [16:0] q, e;
  int err_total = 0, compares = 0;
  // {ref, pd, band gap, buffer, pin, x2, amp, 1k, 100k}
  logic [10:0] rows [8] = '{11'h004, 11'h26c, 11'h41c, 11'h63c, 11'h6aa, 11'h729, 11'h588, 11'h3e8};
  `define CMP(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
  always #5 clk = ~clk;
  dac_config_lock_control DUT (.*);
  dac_host_model HOST (.*);
  function automatic logic [7:0] outs(input int c);
    return {bandgap_on[c], ref_buffer_on[c], ref_pin_connect[c], gain_x2[c], amp_on[c],
      out_load_1k[c], out_load_100k[c], ladder_ref_connect[c]};
  endfunction : outs
  task automatic rst();
    @(posedge clk);
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : rst
  task automatic test_done();
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      HOST.wr(5'h08, {12'h0, {2{rows[i][10:9]}}}, 1'b0);
      HOST.wr(5'h09, {12'h0, {2{rows[i][8:7]}}}, 1'b0);
      HOST.wr(5'h0a, 16'h0300, 1'b0);
      HOST.wr(5'h01, 16'(i), 1'b0);
      HOST.wr(5'h00, 16'h0fff - 16'(i), 1'b1);
      #31;
      `CMP(ladder_tap, {12'(i), 12'hfff - 12'(i)})
      `CMP({outs(1), outs(0)}, {2{rows[i][6:0], rows[i][2]}})
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      value_lock_cfg <= {~k[1], k[1]};
      config_lock_cfg <= {~k[0], k[0]};
      rst();
      e = {13'h1000, ~k[1], ~k[0], k[1], k[0]};
      HOST.rd(5'h0b, q);
      `CMP(q, e)
      HOST.wr(5'h0b, 16'hffff, 1'b1);
      HOST.rd(5'h0b, q);
      `CMP(q, e)
    end
    @(posedge clk);
    {nv_ref_select_field, nv_gain, nv_code} <= {4'hc, 2'h3, 24'h5a5a5a};
    rst();
    #1;
    `CMP({gain_x2, ref_pin_connect, ladder_tap}, {4'ha, 24'h5a5a5a})
    HOST.wr(5'h01, 16'h0000, 1'b0);
    #41;
    `CMP(ladder_tap, 24'h5a5a5a)
    HOST.wr(5'h00, 16'h0123, 1'b1);
    #31;
    `CMP({gain_x2, ladder_tap}, {2'h0, 24'h000123})
    HOST.gc();
    #31;
    `CMP({gain_x2, ladder_tap}, {2'h2, 24'h5a5a5a})
    test_done();
  end
endmodule : tb_dac_config_lock_control
bind dac_config_lock_control dac_config_lock_control_checker CHK (.*);
